// File: src/isd_pkg.sv
// Shared constants, state codes and delay arithmetic for the stereo sample delay line
package isd_pkg;
    localparam int WORD_W = 24;                 // Widest accepted sample word
    localparam int MIN_WORD = 16;               // Shortest accepted sample word
    localparam int CNT_W = 5;                   // Bit counter width within one word
    localparam int SEL_W = 5;                   // Width of the delay select code
    localparam int PTR_W = 13;                  // Frame pointer width
    localparam logic [PTR_W-1:0] DELAY_STEP = 13'h0100;  // Samples added per select code step
    localparam logic [PTR_W-1:0] DELAY_BASE = 13'h00FF;  // Samples at select code zero
    localparam int FRAMES_DEF = 8192;           // Stereo frames of delay memory
    localparam int MAX_DELAY = 8191;            // Samples at the all-ones code, about 170 ms at 48 kHz
    localparam int FIFO_DEPTH = 16;             // Words buffered between receiver and memory
    localparam int TAG_W = WORD_W + 1;          // Sample word plus channel tag
    localparam int CLK_HZ = 200_000_000;        // Rate of ref_clk
    localparam int BCLK_MAX_HZ = 12_288_000;    // Fastest bit clock (64 x 192 kHz)
    localparam int OVERSAMPLE_MIN = 8;          // Ref clocks needed per bit clock period
    localparam int OVERSAMPLE = CLK_HZ / BCLK_MAX_HZ;  // Rounded down
    localparam logic [SEL_W-1:0] SEL_RST = 5'h00;

    typedef enum logic [1:0] {
        ST_CLEAR = 2'b01,
        ST_RUN = 2'b10
    } isd_state_e;

    // Ring length in frames: total delay less the one frame held in the output stage
    function automatic logic [PTR_W-1:0] isd_ring_len(input logic [SEL_W-1:0] code);
        isd_ring_len = 13'((PTR_W'(code) * DELAY_STEP) + DELAY_BASE - 13'h0001);
    endfunction
endpackage

// File: src/isd_fifo.sv
// Small word FIFO between the serial receiver and the delay memory
module isd_fifo #(
    parameter int WIDTH = isd_pkg::TAG_W,
    parameter int DEPTH = isd_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("isd_fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic push, pop;

    // Full and empty from pointers with one wrap bit
    always_comb begin
        in_ready = (wr_r ^ rd_r) != {1'b1, {AW{1'b0}}};
        out_valid = wr_r != rd_r;
        out_data = mem_r[rd_r[AW-1:0]];
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_nxt = push ? wr_r + 1'b1 : wr_r;
        rd_nxt = pop ? rd_r + 1'b1 : rd_r;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
        end
    end

    // Storage needs no reset; only written slots are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_r[AW-1:0]] <= in_data;
        end
    end
endmodule

// File: src/isd_delay_line.sv
// Stereo serial audio delay line: receiver, cleared delay memory with mute, delayed transmitter
module isd_delay_line #(
    parameter int FRAMES = isd_pkg::FRAMES_DEF
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic bit_clk_pin,
    input wire logic word_clk_pin,
    input wire logic serial_in,
    input wire logic [isd_pkg::SEL_W-1:0] delay_select_code,
    output logic serial_out,
    output logic muted
);
    localparam int AW = $clog2(2 * FRAMES);
    localparam logic [AW-1:0] LAST_IDX = AW'(2 * FRAMES - 1);

    if (FRAMES < isd_pkg::MAX_DELAY || FRAMES > (1 << isd_pkg::PTR_W)) begin : g_bad_frames
        $error("FRAMES must hold the longest delay and fit the frame pointer");
    end
    if (isd_pkg::OVERSAMPLE < isd_pkg::OVERSAMPLE_MIN) begin : g_bad_rate
        $error("ref_clk too slow to oversample the fastest bit clock");
    end

    // Pin synchronisers: first stage feeds only the second
    logic [2:0] sync_m_r, sync_m_nxt, sync_s_r, sync_s_nxt;
    logic [isd_pkg::SEL_W-1:0] sel_m_r, sel_m_nxt, sel_s_r, sel_s_nxt;
    logic bclk_d_r, bclk_d_nxt;
    logic bclk_rise, bclk_fall, ws_s, din_s;

    always_comb begin
        sync_m_nxt = {bit_clk_pin, word_clk_pin, serial_in};
        sync_s_nxt = sync_m_r;
        sel_m_nxt = delay_select_code;
        sel_s_nxt = sel_m_r;
        bclk_d_nxt = sync_s_r[2];
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync_m_r <= 3'h0;
            sync_s_r <= 3'h0;
            sel_m_r <= isd_pkg::SEL_RST;
            sel_s_r <= isd_pkg::SEL_RST;
            bclk_d_r <= 1'b0;
        end else begin
            sync_m_r <= sync_m_nxt;
            sync_s_r <= sync_s_nxt;
            sel_m_r <= sel_m_nxt;
            sel_s_r <= sel_s_nxt;
            bclk_d_r <= bclk_d_nxt;
        end
    end

    // Bit clock edges become one-cycle enables; ref_clk only oversamples them
    assign bclk_rise = sync_s_r[2] && !bclk_d_r;
    assign bclk_fall = !sync_s_r[2] && bclk_d_r;
    assign ws_s = sync_s_r[1];
    assign din_s = sync_s_r[0];

    // Receiver: the bit taken at the word clock change is the last bit of the old word
    logic [isd_pkg::WORD_W-1:0] sh_r, sh_nxt, sh_fin;
    logic [isd_pkg::CNT_W-1:0] cnt_r, cnt_nxt, cnt_fin;
    logic ws_prev_r, ws_prev_nxt, started_r, started_nxt, push_r, push_nxt;
    logic [isd_pkg::TAG_W-1:0] push_data_r, push_data_nxt;

    always_comb begin
        sh_fin = sh_r;
        cnt_fin = cnt_r;
        if (cnt_r < isd_pkg::CNT_W'(isd_pkg::WORD_W)) begin
            sh_fin = {sh_r[isd_pkg::WORD_W-2:0], din_s};   // Bits past 24 are dropped
            cnt_fin = cnt_r + 1'b1;
        end
        sh_nxt = sh_r;
        cnt_nxt = cnt_r;
        ws_prev_nxt = ws_prev_r;
        started_nxt = started_r;
        push_nxt = 1'b0;
        push_data_nxt = push_data_r;
        if (bclk_rise) begin
            sh_nxt = sh_fin;
            cnt_nxt = cnt_fin;
            if (ws_s != ws_prev_r) begin
                ws_prev_nxt = ws_s;
                started_nxt = 1'b1;
                sh_nxt = '0;
                cnt_nxt = '0;
                // Word ended; old level names its channel, low is left
                push_nxt = started_r && cnt_fin >= isd_pkg::CNT_W'(isd_pkg::MIN_WORD);
                push_data_nxt = {ws_prev_r,
                    isd_pkg::WORD_W'(sh_fin << (isd_pkg::CNT_W'(isd_pkg::WORD_W) - cnt_fin))};
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sh_r <= '0;
            cnt_r <= '0;
            ws_prev_r <= 1'b0;
            started_r <= 1'b0;
            push_r <= 1'b0;
            push_data_r <= '0;
        end else begin
            sh_r <= sh_nxt;
            cnt_r <= cnt_nxt;
            ws_prev_r <= ws_prev_nxt;
            started_r <= started_nxt;
            push_r <= push_nxt;
            push_data_r <= push_data_nxt;
        end
    end

    // Always drained; words that arrive during the sweep are thrown away so the ring starts on live frames
    logic fifo_in_ready, fifo_valid, fifo_pop;
    logic [isd_pkg::TAG_W-1:0] fifo_data;
    isd_pkg::isd_state_e state_r, state_nxt;

    isd_fifo #(.WIDTH(isd_pkg::TAG_W), .DEPTH(isd_pkg::FIFO_DEPTH)) u_fifo (
        .clk(ref_clk),
        .rst(rst),
        .in_valid(push_r),
        .in_ready(fifo_in_ready),
        .in_data(push_data_r),
        .out_valid(fifo_valid),
        .out_ready(1'b1),
        .out_data(fifo_data)
    );
    assign fifo_pop = fifo_valid && state_r == isd_pkg::ST_RUN;

    // Delay memory: one word per channel per frame, both channels share the pointer
    logic [isd_pkg::WORD_W-1:0] mem_r [2 * FRAMES];
    logic [AW-1:0] idx_r, idx_nxt, mem_addr;
    logic [isd_pkg::PTR_W-1:0] wptr_r, wptr_nxt, ring_len_r, ring_len_nxt, mute_cnt_r, mute_cnt_nxt;
    logic [isd_pkg::SEL_W-1:0] code_r, code_nxt;
    logic muted_r, muted_nxt, mem_we, pop_ch;
    logic [isd_pkg::WORD_W-1:0] mem_wdata, old_word, out_l_r, out_l_nxt, out_r_r, out_r_nxt;

    always_comb begin
        state_nxt = state_r;
        idx_nxt = idx_r;
        wptr_nxt = wptr_r;
        ring_len_nxt = ring_len_r;
        mute_cnt_nxt = mute_cnt_r;
        code_nxt = code_r;
        muted_nxt = muted_r;
        out_l_nxt = out_l_r;
        out_r_nxt = out_r_r;
        pop_ch = fifo_data[isd_pkg::TAG_W-1];
        mem_we = 1'b0;
        mem_addr = AW'({wptr_r, pop_ch});
        mem_wdata = fifo_data[isd_pkg::WORD_W-1:0];
        old_word = mem_r[mem_addr];
        case (state_r)
            isd_pkg::ST_CLEAR: begin
                // Zero sweep; stale audio cannot survive a change
                mem_we = 1'b1;
                mem_addr = idx_r;
                mem_wdata = '0;
                if (idx_r != LAST_IDX) begin
                    idx_nxt = idx_r + 1'b1;
                end else if (fifo_valid && pop_ch) begin    // Open the ring on a frame boundary
                    state_nxt = isd_pkg::ST_RUN;
                    code_nxt = sel_s_r;
                    ring_len_nxt = isd_pkg::isd_ring_len(sel_s_r);
                    wptr_nxt = '0;
                    mute_cnt_nxt = '0;
                    out_l_nxt = '0;
                    out_r_nxt = '0;
                end
            end
            isd_pkg::ST_RUN: begin
                if (sel_s_r != code_r) begin
                    state_nxt = isd_pkg::ST_CLEAR;
                    idx_nxt = '0;
                    muted_nxt = 1'b1;
                    out_l_nxt = '0;                              // Stale audio stops from the next slot; the slot in flight finishes
                    out_r_nxt = '0;
                end else if (fifo_pop) begin
                    mem_we = 1'b1;
                    if (pop_ch) begin
                        out_r_nxt = muted_r ? '0 : old_word;
                        // Pointer moves once per frame so both channels see one delay
                        wptr_nxt = (wptr_r == ring_len_r - 1'b1) ? '0 : wptr_r + 1'b1;
                        if (muted_r) begin
                            mute_cnt_nxt = mute_cnt_r + 1'b1;
                            muted_nxt = mute_cnt_nxt != ring_len_r;
                        end
                    end else begin
                        out_l_nxt = muted_r ? '0 : old_word;
                    end
                end
            end
            default: begin
                state_nxt = isd_pkg::ST_CLEAR;
                idx_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= isd_pkg::ST_CLEAR;
            idx_r <= '0;
            wptr_r <= '0;
            ring_len_r <= isd_pkg::DELAY_BASE;
            mute_cnt_r <= '0;
            code_r <= isd_pkg::SEL_RST;
            muted_r <= 1'b1;
            out_l_r <= '0;
            out_r_r <= '0;
        end else begin
            state_r <= state_nxt;
            idx_r <= idx_nxt;
            wptr_r <= wptr_nxt;
            ring_len_r <= ring_len_nxt;
            mute_cnt_r <= mute_cnt_nxt;
            code_r <= code_nxt;
            muted_r <= muted_nxt;
            out_l_r <= out_l_nxt;
            out_r_r <= out_r_nxt;
        end
    end

    // Memory array has no reset; the sweep after reset clears it
    always_ff @(posedge ref_clk) begin
        if (mem_we) begin
            mem_r[mem_addr] <= mem_wdata;
        end
    end

    // Transmitter: MSB leaves on the fall after the word clock change is seen, as in the input
    logic tx_ws_r, tx_ws_nxt, so_r, so_nxt, tx_load;
    logic [isd_pkg::WORD_W-1:0] tx_sh_r, tx_sh_nxt, tx_word;

    always_comb begin
        tx_ws_nxt = tx_ws_r;
        tx_sh_nxt = tx_sh_r;
        so_nxt = so_r;
        tx_word = ws_prev_r ? out_r_r : out_l_r;
        tx_load = bclk_fall && ws_prev_r != tx_ws_r;
        if (tx_load) begin
            tx_ws_nxt = ws_prev_r;
            so_nxt = tx_word[isd_pkg::WORD_W-1];
            tx_sh_nxt = {tx_word[isd_pkg::WORD_W-2:0], 1'b0};
        end else if (bclk_fall) begin
            so_nxt = tx_sh_r[isd_pkg::WORD_W-1];                 // Zero padding fills long slots
            tx_sh_nxt = {tx_sh_r[isd_pkg::WORD_W-2:0], 1'b0};
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_ws_r <= 1'b0;
            tx_sh_r <= '0;
            so_r <= 1'b0;
        end else begin
            tx_ws_r <= tx_ws_nxt;
            tx_sh_r <= tx_sh_nxt;
            so_r <= so_nxt;
        end
    end

    assign serial_out = so_r;
    assign muted = muted_r;

    // Checks on the clear, mute, delay and framing behaviour
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_change_clears;
        state_r == isd_pkg::ST_RUN && sel_s_r != code_r |=> state_r == isd_pkg::ST_CLEAR && idx_r == '0;
    endproperty
    a_change_clears: assert property (p_change_clears) else $error("select change did not start a clear");

    property p_clear_span;
        $rose(state_r == isd_pkg::ST_RUN) |-> $past(idx_r) == LAST_IDX && muted_r;
    endproperty
    a_clear_span: assert property (p_clear_span) else $error("clear ended before the last word");

    property p_muted_zero;
        state_r == isd_pkg::ST_RUN && fifo_pop && muted_r && sel_s_r == code_r
            |=> ($past(pop_ch) ? out_r_r : out_l_r) == '0;
    endproperty
    a_muted_zero: assert property (p_muted_zero) else $error("audio left the memory while muted");

    property p_mute_bound;
        muted_r && state_r == isd_pkg::ST_RUN |-> mute_cnt_r < ring_len_r;
    endproperty
    a_mute_bound: assert property (p_mute_bound) else $error("mute held past the delay length");

    property p_wptr_range;
        state_r == isd_pkg::ST_RUN |-> wptr_r < ring_len_r && ring_len_r[7:0] == 8'hFE;
    endproperty
    a_wptr_range: assert property (p_wptr_range) else $error("frame pointer outside the ring");

    property p_left_holds_ptr;
        fifo_pop && !pop_ch && sel_s_r == code_r |=> $stable(wptr_r);
    endproperty
    a_left_holds_ptr: assert property (p_left_holds_ptr) else $error("left word moved the pointer");

    property p_rx_on_rise;
        $changed(cnt_r) |-> $past(bclk_rise);
    endproperty
    a_rx_on_rise: assert property (p_rx_on_rise) else $error("receiver moved without a bit clock rise");

    property p_tx_msb;
        tx_load |=> serial_out == $past(tx_word[isd_pkg::WORD_W-1]) ##1 $stable(serial_out) [*2];
    endproperty
    a_tx_msb: assert property (p_tx_msb) else $error("output word did not start with its MSB");

    property p_push_len;
        push_r |-> $past(cnt_fin) >= isd_pkg::CNT_W'(isd_pkg::MIN_WORD) && $past(bclk_rise);
    endproperty
    a_push_len: assert property (p_push_len) else $error("short or untimed word was stored");
endmodule

// File: bench/isd_tb_pkg.sv
// Sample pattern shared by the audio source model and the bench's expectations
package isd_tb_pkg;
    // Frame number in the top 16 bits, inverted on the right channel; significant bits cycle 16, 20, 24 with the rest cleared, whatever the slot length
    function automatic logic [31:0] word_of(input logic [15:0] f, input logic ch);
        logic [23:0] v;
        v = ch ? {~f, 8'h5A} : {f, 8'hA5};
        v = v & ~(24'hFFFFFF >> (16 + 4 * (f % 3)));
        word_of = {v, 8'h00};
    endfunction
endpackage

// File: bench/isd_i2s_model.sv
// Audio source and downstream receiver: drives the serial input, collects the delayed output slots
module isd_i2s_model #(
    parameter int HALF = 8
) (
    input wire logic ref_clk,
    input wire logic [5:0] slot_bits,
    input wire logic serial_out,
    output logic bit_clk,
    output logic word_clk,
    output logic serial_in,
    output logic rx_valid,
    output logic rx_ch,
    output logic [23:0] rx_word,
    output logic [15:0] rx_fr
);
    timeunit 1ns;
    timeprecision 100ps;
    int ph = 0;
    int bp = 47;
    int slot_r = 24;
    int cnt = 31;
    logic ws_seen = 1'b1;
    logic [15:0] fr = 16'h0000;
    logic [15:0] cur_fr = 16'h0000;
    logic [31:0] sh = 32'h00000000;
    logic [23:0] cur = 24'h000000;

    // Power-on levels of the source lines
    initial begin
        bit_clk = 1'b0;
        word_clk = 1'b1;
        serial_in = 1'b0;
        rx_valid = 1'b0;
        rx_ch = 1'b0;
        rx_word = 24'h000000;
        rx_fr = 16'h0000;
    end

    // Bit clock from a phase counter at 50 percent duty; it runs without pause, as a real source does
    always @(posedge ref_clk) begin
        rx_valid <= 1'b0;
        if (ph == HALF - 1) begin
            ph = 0;
            bit_clk <= ~bit_clk;
            if (bit_clk) begin
                // Falling edge: clocks and data move half a period clear of the sampling rises
                bp = (bp + 1) % (2 * slot_r);
                if (bp == 0) begin
                    slot_r = int'(slot_bits);
                    fr = fr + 16'h0001;
                end
                word_clk <= (bp >= slot_r);
                if (bp % slot_r == 1) begin
                    sh = isd_tb_pkg::word_of(fr, bp >= slot_r);  // MSB one bit after the change
                end
                serial_in <= sh[31];
                sh = sh << 1;
            end else begin
                // Rising edge: gather the delayed slot the way a cascaded stage would
                if (cnt <= 23) begin
                    cur[23 - cnt] = serial_out;
                end
                if (word_clk != ws_seen) begin
                    rx_valid <= 1'b1;
                    rx_ch <= ws_seen;
                    rx_word <= cur;
                    rx_fr <= cur_fr;
                    cur = 24'h000000;
                    cnt = 0;
                    cur_fr = fr;
                    ws_seen = word_clk;
                end else begin
                    cnt = cnt + 1;
                end
            end
        end else begin
            ph = ph + 1;
        end
    end
endmodule

// File: bench/isd_delay_line_tb.sv
// Self-checking bench for the stereo sample delay line
module isd_delay_line_tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {
        logic [4:0] code;
        logic [5:0] slot;
        logic [15:0] dly;
    } isd_row_s;
    // Select code and slot length in, delay in frames expected out
    isd_row_s rows [3] = '{'{5'h00, 6'h18, 16'h00FF}, '{5'h01, 6'h10, 16'h01FF}, '{5'h00, 6'h20, 16'h00FF}};
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] code = 5'h00;
    logic [5:0] slot = 6'h18;
    logic [15:0] exp_d = 16'h00FF;
    logic bit_clk_pin;
    logic word_clk_pin;
    logic serial_in;
    logic serial_out;
    logic muted;
    logic rx_valid;
    logic rx_ch;
    logic [23:0] rx_word;
    logic [15:0] rx_fr;
    logic [15:0] k;
    logic [31:0] w;
    logic mprev = 1'b1;
    logic mprev2 = 1'b1;
    logic last_so = 1'b0;
    logic last_bclk = 1'b0;
    int num_errors = 0;
    int n_compared = 0;
    int n_real = 0;
    int tmo;

    isd_delay_line #(.FRAMES(isd_pkg::FRAMES_DEF)) i_isd_delay_line (
        .ref_clk(ref_clk),
        .rst(rst),
        .bit_clk_pin(bit_clk_pin),
        .word_clk_pin(word_clk_pin),
        .serial_in(serial_in),
        .delay_select_code(code),
        .serial_out(serial_out),
        .muted(muted)
    );

    isd_i2s_model #(.HALF(8)) i_isd_i2s_model (
        .ref_clk(ref_clk),
        .slot_bits(slot),
        .serial_out(serial_out),
        .bit_clk(bit_clk_pin),
        .word_clk(word_clk_pin),
        .serial_in(serial_in),
        .rx_valid(rx_valid),
        .rx_ch(rx_ch),
        .rx_word(rx_word),
        .rx_fr(rx_fr)
    );

    // 200 MHz reference
    always #2.5 ref_clk = ~ref_clk;

    task automatic miss(input string msg);
        num_errors++;
        $display("MISMATCH %0t %s", $time, msg);
    endtask

    task automatic summarize();
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Each finished slot: silent while muted, else the sample of D frames back
    // Mute falls half a frame before the last zero slot leaves, so two slots after the fall are skipped
    always @(posedge ref_clk) begin
        if (rx_valid) begin
            k = rx_ch ? ~rx_word[23:8] : rx_word[23:8];
            w = isd_tb_pkg::word_of(k, rx_ch);
            if (muted === 1'b1 && mprev === 1'b1) begin
                n_compared++;
                if (rx_word !== 24'h000000) miss("muted slot carries data");
            end else if (muted === 1'b0 && mprev === 1'b0 && mprev2 === 1'b0) begin
                n_compared += 2;
                if (rx_word !== (w[31:8] & ~(24'hFFFFFF >> slot))) miss("wrong sample or channel");
                if (16'(rx_fr - k) !== exp_d) miss("wrong delay");
                n_real++;
            end
            mprev2 = mprev;
            mprev = muted;
        end
    end

    // Output must hold still while the bit clock is high so a receiver can sample at the rise
    always @(posedge ref_clk) begin
        if (rst === 1'b0 && bit_clk_pin && last_bclk) begin
            n_compared++;
            if (serial_out !== last_so) miss("output moved while bit clock high");
        end
        last_so <= serial_out;
        last_bclk <= bit_clk_pin;
    end

    // Rows: restart on each code change, then wait for unmuted audio; the wait is bounded
    initial begin
        repeat (6) @(posedge ref_clk);
        n_compared++;
        if (muted !== 1'b1 || serial_out !== 1'b0) miss("outputs active in reset");
        rst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].code !== code) begin
                code <= rows[i].code;
                repeat (8) @(posedge ref_clk);
                n_compared++;
                if (muted !== 1'b1) miss("no mute after select change");
            end
            slot <= rows[i].slot;
            exp_d <= rows[i].dly;
            n_real = 0;
            tmo = 0;
            while (n_real < 12 && tmo < 400000) begin
                @(posedge ref_clk);
                tmo++;
            end
            if (n_real < 12) miss("no delayed audio in time");
        end
        // Reset in mid-stream silences at once and starts a fresh clear
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        n_compared++;
        if (muted !== 1'b1 || serial_out !== 1'b0) miss("reset did not silence output");
        rst <= 1'b0;
        repeat (2000) @(posedge ref_clk);
        n_compared++;
        if (muted !== 1'b1) miss("mute lifted during memory clear");
        summarize();
    end
endmodule
